// ### core/isc_scaler.sv
// Scaler position generator feeding a 5-tap filter window.
// Assumes pixel reader, output consumer and register port share clk.
// How it works
// - Output positions snap to a 1/32 input-pixel grid in both axes.
// - Horizontal and vertical distances are tracked with 16 fraction bits.
// - Position is start coordinate plus output index over scale factor.
// - Integer part picks nearest input pixel; fraction is distance onward.
// - Phase is five bits, centred, from -16/32 to +15/32.
// - Positions advance by inverse-scale increments once per output.
// - Increments are 16 integer bits plus 16 fraction bits.
// - Top five fraction bits address coefficients; counters keep full precision.
// - Integer advance gives number of input pixels fetched and shifted.
// - Upscaling advance is zero or one, from the fraction carry.
// - Shift-all mode shifts every read pixel through all five taps.
// - Shift-bypass mode skips all reads of an advance but the last.
// - Shift-bypass forces the coefficient address to zero.
// - Y, U, V gather into a triplet; results go to PCI or SDRAM.
// - Red is luma plus V plus three eighths of V.
// - Blue is luma plus U plus forty-seven sixty-fourths of U.
// - Chroma top bit is inverted to get signed values.
// - In shift-all mode the centre tap is nearest input pixel with two on each side.
// - At line end shifting and advancing stop; last output repeats.
`timescale 1ns/100ps
module isc_scaler (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic [7:0]         reg_addr,
	input  wire logic [31:0]        reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output      logic [31:0]        reg_rdata,
	input  wire logic               pix_valid,
	input  wire logic [7:0]         pix_data,
	output      logic               pix_ready,
	output      logic               out_valid,
	input  wire logic               out_ready,
	output      isc_pkg::isc_taps_t out_taps,
	output      logic [4:0]         out_phase,
	output      logic               line_busy,
	output      isc_pkg::isc_vpos_t vpos,
	output      logic [15:0]        v_advance,
	input  wire logic               ycc_valid,
	input  wire isc_pkg::isc_comp_t ycc_comp,
	input  wire logic [7:0]         ycc_data,
	output      logic               pci_valid,
	output      logic               sdram_valid,
	output      isc_pkg::isc_rgb_t  rgb
);
	logic        rst_m;
	logic        rst_q;
	logic        bypass;
	logic        to_sdram;
	logic [31:0] x_start;
	logic [31:0] x_inc;
	logic [31:0] y_start;
	logic [31:0] y_inc;
	logic [15:0] line_len;
	logic [15:0] out_len;
	isc_pkg::isc_state_t state;
	isc_pkg::isc_state_t next_state;
	logic [31:0] acc;
	logic [31:0] next_acc;
	logic [31:0] step;
	logic [31:0] start_pos;
	logic [15:0] adv;
	logic [15:0] left;
	logic [15:0] next_left;
	logic [15:0] rd_cnt;
	logic [15:0] next_rd;
	logic [15:0] outs_left;
	logic [15:0] next_outs;
	logic        eol;
	logic        next_eol;
	logic        priming;
	logic        next_prime;
	logic        accept;
	logic        taken;
	logic        line_go;
	logic        win_go;
	logic        line_done;
	logic [31:0] y_acc;
	logic [31:0] y_step;

	// ********************************
	// Reset release
	// ********************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_m <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			rst_m <= 1'b1;
			rst_q <= rst_m;
		end
	end

	// ********************************
	// Register port
	// ********************************
	assign line_go = reg_wr && reg_addr == isc_pkg::REG_CTRL
		&& reg_wdata[isc_pkg::CTRL_LINE_GO];
	assign win_go = reg_wr && reg_addr == isc_pkg::REG_CTRL
		&& reg_wdata[isc_pkg::CTRL_WIN_GO];

	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			bypass   <= 1'b0;
			to_sdram <= 1'b0;
			x_start  <= isc_pkg::START_RST;
			x_inc    <= isc_pkg::INC_UNITY;
			y_start  <= isc_pkg::START_RST;
			y_inc    <= isc_pkg::INC_UNITY;
			line_len <= isc_pkg::LEN_RST;
			out_len  <= isc_pkg::LEN_RST;
		end else if (reg_wr) begin
			unique case (reg_addr)
				isc_pkg::REG_CTRL: begin
					bypass   <= reg_wdata[isc_pkg::CTRL_BYPASS];
					to_sdram <= reg_wdata[isc_pkg::CTRL_TO_SDRAM];
				end
				isc_pkg::REG_X_START:  x_start  <= reg_wdata;
				isc_pkg::REG_X_INC:    x_inc    <= reg_wdata;
				isc_pkg::REG_Y_START:  y_start  <= reg_wdata;
				isc_pkg::REG_Y_INC:    y_inc    <= reg_wdata;
				isc_pkg::REG_LINE_LEN: line_len <= reg_wdata[15:0];
				isc_pkg::REG_OUT_LEN:  out_len  <= reg_wdata[15:0];
				default: begin
					bypass <= bypass;
				end
			endcase
		end
	end

	// Unmapped reads return zero
	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				isc_pkg::REG_CTRL:     reg_rdata <= {30'h0, to_sdram, bypass};
				isc_pkg::REG_X_START:  reg_rdata <= x_start;
				isc_pkg::REG_X_INC:    reg_rdata <= x_inc;
				isc_pkg::REG_Y_START:  reg_rdata <= y_start;
				isc_pkg::REG_Y_INC:    reg_rdata <= y_inc;
				isc_pkg::REG_LINE_LEN: reg_rdata <= {16'h0, line_len};
				isc_pkg::REG_OUT_LEN:  reg_rdata <= {16'h0, out_len};
				isc_pkg::REG_X_POS:    reg_rdata <= acc;
				isc_pkg::REG_Y_POS:    reg_rdata <= y_acc;
				isc_pkg::REG_STATUS:   reg_rdata <= {rd_cnt, 12'h0, priming,
					eol, state};
				default:               reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// ********************************
	// Horizontal position sequencer
	// ********************************
	assign accept    = pix_valid && pix_ready;
	assign taken     = out_valid && out_ready;
	// Rounding by a half makes the integer the nearest pixel
	assign start_pos = x_start + isc_pkg::POS_HALF;
	assign step      = acc + x_inc;
	// Integer difference carries the fraction overflow too
	assign adv       = step[31:16] - acc[31:16];
	assign line_done = state == isc_pkg::ST_EMIT && taken
		&& outs_left == isc_pkg::ONE_READ;

	always_comb begin
		next_state = state;
		next_acc   = acc;
		next_left  = left;
		next_rd    = rd_cnt;
		next_eol   = eol;
		next_outs  = outs_left;
		next_prime = priming;
		unique case (state)
			isc_pkg::ST_IDLE: begin
				if (line_go && out_len != isc_pkg::LEN_RST) begin
					next_acc   = start_pos;
					// Negative starts cannot read before pixel zero
					next_left  = start_pos[31] ? isc_pkg::PRIME_READS
						: start_pos[31:16] + isc_pkg::PRIME_READS;
					next_rd    = isc_pkg::LEN_RST;
					next_eol   = 1'b0;
					next_outs  = out_len;
					next_prime = 1'b1;
					next_state = isc_pkg::ST_FETCH;
				end
			end
			isc_pkg::ST_FETCH: begin
				if (accept) begin
					next_left = left - isc_pkg::ONE_READ;
					next_rd   = rd_cnt + isc_pkg::ONE_READ;
					if (rd_cnt == line_len)
						next_eol = 1'b1;
				end
				if (next_left == isc_pkg::LEN_RST || next_eol) begin
					next_left  = isc_pkg::LEN_RST;
					next_prime = 1'b0;
					next_state = isc_pkg::ST_EMIT;
				end
			end
			isc_pkg::ST_EMIT: begin
				if (taken) begin
					next_outs = outs_left - isc_pkg::ONE_READ;
					if (outs_left == isc_pkg::ONE_READ) begin
						next_state = isc_pkg::ST_IDLE;
					end else if (!eol) begin
						next_acc  = step;
						next_left = adv;
						if (adv != isc_pkg::LEN_RST)
							next_state = isc_pkg::ST_FETCH;
					end
				end
			end
			default: begin
				next_state = isc_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			state     <= isc_pkg::ST_IDLE;
			acc       <= isc_pkg::START_RST;
			left      <= isc_pkg::LEN_RST;
			rd_cnt    <= isc_pkg::LEN_RST;
			eol       <= 1'b0;
			outs_left <= isc_pkg::LEN_RST;
			priming   <= 1'b0;
		end else begin
			state     <= next_state;
			acc       <= next_acc;
			left      <= next_left;
			rd_cnt    <= next_rd;
			eol       <= next_eol;
			outs_left <= next_outs;
			priming   <= next_prime;
		end
	end

	// Ready is registered, so it is computed from next values
	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			pix_ready <= 1'b0;
			out_valid <= 1'b0;
			line_busy <= 1'b0;
			out_phase <= isc_pkg::PHASE_ZERO;
		end else begin
			pix_ready <= next_state == isc_pkg::ST_FETCH
				&& next_left != isc_pkg::LEN_RST && !next_eol;
			out_valid <= next_state == isc_pkg::ST_EMIT;
			line_busy <= next_state != isc_pkg::ST_IDLE;
			// Only the top fraction bits leave; acc keeps all sixteen
			out_phase <= bypass ? isc_pkg::PHASE_ZERO
				: isc_pkg::isc_phase(next_acc);
		end
	end

	// ********************************
	// Tap shift register
	// ********************************
	// Bypass keeps only the last read of an advance; priming fills all
	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			out_taps <= '0;
		end else if (accept && (!bypass || priming
				|| left == isc_pkg::ONE_READ)) begin
			out_taps <= {out_taps[isc_pkg::TAPS-2:0], pix_data};
		end
	end

	// ********************************
	// Vertical position
	// ********************************
	assign y_step = y_acc + y_inc;

	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			y_acc     <= isc_pkg::START_RST;
			vpos      <= '0;
			v_advance <= isc_pkg::LEN_RST;
		end else if (win_go) begin
			y_acc      <= y_start + isc_pkg::POS_HALF;
			vpos.line  <= y_start[31:16] + 16'(y_start[15]);
			vpos.phase <= isc_pkg::isc_phase(y_start + isc_pkg::POS_HALF);
			v_advance  <= isc_pkg::LEN_RST;
		end else if (line_done) begin
			y_acc      <= y_step;
			vpos.line  <= y_step[31:16];
			vpos.phase <= isc_pkg::isc_phase(y_step);
			v_advance  <= y_step[31:16] - y_acc[31:16];
		end
	end

	// ********************************
	// Colour conversion
	// ********************************
	isc_yuv2rgb i_isc_yuv2rgb (
		.clk         (clk),
		.rst_n       (rst_q),
		.to_sdram    (to_sdram),
		.ycc_valid   (ycc_valid),
		.ycc_comp    (ycc_comp),
		.ycc_data    (ycc_data),
		.pci_valid   (pci_valid),
		.sdram_valid (sdram_valid),
		.rgb         (rgb)
	);

	// ********************************
	// Checks
	// ********************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_q);

	bypass_phase_a: assert property (out_valid && bypass |-> out_phase == 0)
		else $error("phase not zero in bypass");
	phase_map_a: assert property (out_valid && !bypass |->
		out_phase == {~acc[15], acc[14:11]})
		else $error("phase does not match position");
	line_load_a: assert property (state == isc_pkg::ST_IDLE
		&& next_state == isc_pkg::ST_FETCH |=>
		acc == $past(x_start) + isc_pkg::POS_HALF)
		else $error("start offset not loaded");
	acc_step_a: assert property (state == isc_pkg::ST_EMIT && taken && !eol
		&& outs_left != 1 |=> acc == $past(acc) + $past(x_inc))
		else $error("position did not advance by increment");
	eol_hold_a: assert property (eol && state == isc_pkg::ST_EMIT
		|=> $stable(acc) && !pix_ready)
		else $error("advance after end of line");
	upscale_adv_a: assert property (state == isc_pkg::ST_EMIT && taken
		&& !eol && outs_left != 1 && x_inc[31:16] == 0 |=> left <= 1)
		else $error("upscale advance above one");
	shift_all_a: assert property (accept && !bypass
		|=> out_taps[0] == $past(pix_data)
		&& out_taps[1] == $past(out_taps[0]))
		else $error("pixel not shifted in");
	bypass_skip_a: assert property (accept && bypass && !priming && left > 1
		|=> $stable(out_taps))
		else $error("skipped pixel reached taps");
	fetch_done_a: assert property (state == isc_pkg::ST_FETCH && accept
		&& left == 1 |=> out_valid ##0 !pix_ready)
		else $error("no output after advance reads");
endmodule

// ### shared/isc_pkg.sv
// Shared constants and types for the image scaler position engine.
// Assumes a single 10 MHz clock and a 32-bit word register port.
package isc_pkg;

	// ********************************
	// Register map (byte addresses)
	// ********************************
	localparam int AW = 8;
	localparam int DW = 32;
	localparam logic [AW-1:0] REG_CTRL     = 8'h00;
	localparam logic [AW-1:0] REG_X_START  = 8'h04;
	localparam logic [AW-1:0] REG_X_INC    = 8'h08;
	localparam logic [AW-1:0] REG_Y_START  = 8'h0C;
	localparam logic [AW-1:0] REG_Y_INC    = 8'h10;
	localparam logic [AW-1:0] REG_LINE_LEN = 8'h14;
	localparam logic [AW-1:0] REG_OUT_LEN  = 8'h18;
	localparam logic [AW-1:0] REG_X_POS    = 8'h1C;
	localparam logic [AW-1:0] REG_Y_POS    = 8'h20;
	localparam logic [AW-1:0] REG_STATUS   = 8'h24;

	// Control bits
	localparam int CTRL_BYPASS  = 0;
	localparam int CTRL_TO_SDRAM = 1;
	localparam int CTRL_LINE_GO = 2;
	localparam int CTRL_WIN_GO  = 3;

	// ********************************
	// Position format: 16.16 fixed point
	// ********************************
	localparam int FRAC_W  = 16;
	localparam int INT_W   = 16;
	localparam int POS_W   = INT_W + FRAC_W;
	localparam int PHASE_W = 5;
	localparam logic [POS_W-1:0] POS_HALF  = 32'h0000_8000;
	localparam logic [POS_W-1:0] INC_UNITY = 32'h0001_0000;
	localparam logic [POS_W-1:0] START_RST = 32'h0000_0000;
	localparam logic [INT_W-1:0] LEN_RST   = 16'h0000;
	localparam logic [PHASE_W-1:0] PHASE_ZERO = 5'h00;

	// ********************************
	// Filter shape
	// ********************************
	localparam int TAPS  = 5;
	localparam int PIX_W = 8;
	localparam logic [INT_W-1:0] PRIME_READS = 16'h0003;
	localparam logic [INT_W-1:0] ONE_READ    = 16'h0001;

	// ********************************
	// Colour conversion
	// ********************************
	localparam logic [PIX_W-1:0] CHROMA_FLIP = 8'h80;
	localparam logic signed [13:0] R_NUM = 14'sh0003;
	localparam int R_SHIFT = 3;
	localparam logic signed [13:0] B_NUM = 14'sh002F;
	localparam int B_SHIFT = 6;
	localparam logic signed [13:0] PIX_MAX = 14'sh00FF;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_FETCH = 2'b01,
		ST_EMIT  = 2'b10
	} isc_state_t;

	typedef enum logic [1:0] {
		COMP_Y = 2'b00,
		COMP_U = 2'b01,
		COMP_V = 2'b10
	} isc_comp_t;

	typedef logic [TAPS-1:0][PIX_W-1:0] isc_taps_t;

	typedef struct packed {
		logic [INT_W-1:0]   line;
		logic [PHASE_W-1:0] phase;
	} isc_vpos_t;

	typedef struct packed {
		logic [PIX_W-1:0] r;
		logic [PIX_W-1:0] y;
		logic [PIX_W-1:0] b;
	} isc_rgb_t;

	// Signed phase of a rounded position, -16..+15 in 32nds
	function automatic logic [PHASE_W-1:0] isc_phase(
		input logic [POS_W-1:0] p);
		return {~p[FRAC_W-1], p[FRAC_W-2:FRAC_W-PHASE_W]};
	endfunction

endpackage

// ### core/isc_yuv2rgb.sv
// Gathers Y, U, V bytes into a 4:4:4 triplet and converts to R and B.
// Assumes the feeder delivers components on the same clock.
`timescale 1ns/100ps
module isc_yuv2rgb (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              to_sdram,
	input  wire logic              ycc_valid,
	input  wire isc_pkg::isc_comp_t ycc_comp,
	input  wire logic [7:0]        ycc_data,
	output      logic              pci_valid,
	output      logic              sdram_valid,
	output      isc_pkg::isc_rgb_t rgb
);
	logic              have_y;
	logic              have_u;
	logic [7:0]        y_r;
	logic signed [7:0] u_r;
	logic signed [7:0] v_in;
	logic signed [13:0] r_sum;
	logic signed [13:0] b_sum;
	logic              fire;

	function automatic logic [7:0] clamp(input logic signed [13:0] s);
		if (s < 0)
			return 8'h00;
		if (s > isc_pkg::PIX_MAX)
			return 8'hFF;
		return s[7:0];
	endfunction

	// ********************************
	// Triplet gathering
	// ********************************
	assign v_in = signed'(ycc_data ^ isc_pkg::CHROMA_FLIP);
	assign fire = ycc_valid && ycc_comp == isc_pkg::COMP_V
		&& have_y && have_u;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			have_y <= 1'b0;
			have_u <= 1'b0;
			y_r    <= 8'h00;
			u_r    <= 8'sh00;
		end else if (ycc_valid) begin
			unique case (ycc_comp)
				isc_pkg::COMP_Y: begin
					y_r    <= ycc_data;
					have_y <= 1'b1;
				end
				isc_pkg::COMP_U: begin
					u_r    <= signed'(ycc_data ^ isc_pkg::CHROMA_FLIP);
					have_u <= 1'b1;
				end
				isc_pkg::COMP_V: begin
					have_y <= 1'b0;
					have_u <= 1'b0;
				end
				default: begin
					have_y <= have_y;
				end
			endcase
		end
	end

	// ********************************
	// Conversion, constant multiply, arithmetic shift and add
	// ********************************
	always_comb begin
		r_sum = 14'($signed({6'h00, y_r})) + 14'(v_in)
			+ ((14'(v_in) * isc_pkg::R_NUM) >>> isc_pkg::R_SHIFT);
		b_sum = 14'($signed({6'h00, y_r})) + 14'(u_r)
			+ ((14'(u_r) * isc_pkg::B_NUM) >>> isc_pkg::B_SHIFT);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pci_valid   <= 1'b0;
			sdram_valid <= 1'b0;
			rgb         <= '0;
		end else begin
			pci_valid   <= fire && !to_sdram;
			sdram_valid <= fire && to_sdram;
			if (fire) begin
				rgb.r <= clamp(r_sum);
				rgb.y <= y_r;
				rgb.b <= clamp(b_sum);
			end
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	red_calc_a: assert property (fire |=> rgb.r == clamp($past(r_sum)))
		else $error("red result wrong");
	blue_calc_a: assert property (fire |=> rgb.b == clamp($past(b_sum)))
		else $error("blue result wrong");
	route_dest_a: assert property (fire && to_sdram |=> sdram_valid && !pci_valid)
		else $error("result sent to wrong path");
endmodule

// ### testbench/isc_pix_src.sv
// Pixel memory reader model: pixel k of a line carries the value k.
// Assumes the scaler samples pix_valid and pix_data on rising clk.
`timescale 1ns/100ps
module isc_pix_src (
	input  wire logic       clk,
	input  wire logic       clr,
	input  wire logic       slow,
	input  wire logic       pix_ready,
	output      logic       pix_valid,
	output      logic [7:0] pix_data,
	output      int         taken
);
	// ********************************
	// Offer and count
	// ********************************
	logic gap;

	// Slow mode offers every other cycle to stall the fetch
	always_ff @(posedge clk) begin
		if (clr) begin
			gap   <= 1'b0;
			taken <= 0;
		end else begin
			gap <= slow ? ~gap : 1'b0;
			if (pix_valid && pix_ready) begin
				taken <= taken + 1;
			end
		end
	end

	// Idle data inverted, so a stale value never passes
	assign pix_valid = ~gap;
	assign pix_data  = pix_valid ? taken[7:0] : ~taken[7:0];
endmodule

// ### testbench/isc_scaler_tb.sv
// Self-checking bench for the scaler position engine and colour path.
// Assumes the pixel reader model; the bench plays consumer and software.
`timescale 1ns/100ps
module isc_scaler_tb;
	// ********************************
	// Signals
	// ********************************
	logic               clk = 1'b0;
	logic               rst_n = 1'b0;
	logic [7:0]         reg_addr = 8'h00;
	logic [31:0]        reg_wdata = 32'h0;
	logic               reg_wr = 1'b0;
	logic               reg_rd = 1'b0;
	logic [31:0]        reg_rdata;
	logic               pix_valid, pix_ready, out_valid, line_busy;
	logic [7:0]         pix_data;
	logic               out_ready = 1'b0;
	isc_pkg::isc_taps_t out_taps;
	logic [4:0]         out_phase;
	isc_pkg::isc_vpos_t vpos;
	logic [15:0]        v_advance;
	logic               ycc_valid = 1'b0;
	isc_pkg::isc_comp_t ycc_comp = isc_pkg::COMP_Y;
	logic [7:0]         ycc_data = 8'h00;
	logic               pci_valid, sdram_valid;
	isc_pkg::isc_rgb_t  rgb;
	logic               clr = 1'b1;
	logic               slow = 1'b0;
	int                 taken, error_cnt = 0, checks_done = 0;
	logic [31:0]        y, y_inc, v32;

	isc_scaler i_isc_scaler (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pix_valid(pix_valid), .pix_data(pix_data),
		.pix_ready(pix_ready), .out_valid(out_valid), .out_ready(out_ready),
		.out_taps(out_taps), .out_phase(out_phase), .line_busy(line_busy),
		.vpos(vpos), .v_advance(v_advance), .ycc_valid(ycc_valid),
		.ycc_comp(ycc_comp), .ycc_data(ycc_data), .pci_valid(pci_valid),
		.sdram_valid(sdram_valid), .rgb(rgb));

	isc_pix_src i_isc_pix_src (.clk(clk), .clr(clr), .slow(slow),
		.pix_ready(pix_ready), .pix_valid(pix_valid),
		.pix_data(pix_data), .taken(taken));

	initial begin
		forever #50 clk = ~clk;
	end

	// ********************************
	// Tasks
	// ********************************
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("Counts: %0d checks, %0d errors", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		// One idle edge so a following call never re-raises the strobe
		@(posedge clk);
	endtask

	// Data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
		@(posedge clk);
	endtask

	task automatic run_line(input logic [31:0] st, input logic [31:0] inc,
		input int n_out, input int len, input logic byp, input logic sl);
		logic [31:0] p;
		logic [44:0] prev;
		int c, over, need;
		clr <= 1'b1;
		slow <= sl;
		wr(isc_pkg::REG_X_START, st);
		clr <= 1'b0;
		wr(isc_pkg::REG_X_INC, inc);
		wr(isc_pkg::REG_LINE_LEN, len);
		wr(isc_pkg::REG_OUT_LEN, n_out);
		wr(isc_pkg::REG_CTRL, {29'h0, 2'b10, byp});
		p = st + 32'h0000_8000;
		over = 0;
		prev = '0;
		for (int n = 0; n < n_out; n++) begin
			c = 0;
			do begin
				@(negedge clk);
				c++;
			end while (out_valid !== 1'b1 && c < 300);
			if (c >= 300) begin
				error_cnt++;
				close_out();
			end
			if (32'(p[31:16]) + 2 <= len) begin
				chk(out_taps[0], p[31:16] + 16'h2);
				chk(out_phase, byp ? 5'h00 : {~p[15], p[14:11]});
				if (!byp) begin
					chk(out_taps[2], p[31:16]);
				end else if (n > 0) begin
					chk(out_taps[1], prev[7:0]);
				end
				need = 32'(p[31:16]) + 3;
			end else begin
				chk(out_taps[0], len);
				if (over > 0) begin
					chk({out_phase, out_taps}, prev);
				end
				over++;
				need = len + 1;
			end
			prev = {out_phase, out_taps};
			p = p + inc;
			@(posedge clk);
			out_ready <= 1'b1;
			@(posedge clk);
			out_ready <= 1'b0;
		end
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (line_busy !== 1'b0 && c < 50);
		chk(c < 50, 1'b1);
		chk(taken, need);
		repeat (2) @(negedge clk);
		v32 = y;
		y = y + y_inc;
		chk(vpos, {y[31:16], ~y[15], y[14:11]});
		chk(v_advance, y[31:16] - v32[31:16]);
		@(posedge clk);
		$display("Line test done at %0t", $time);
	endtask

	task automatic yuv(input logic [7:0] yy, input logic [7:0] u,
		input logic [7:0] v, input logic sd);
		logic signed [13:0] su, sv, r, b;
		su = {{6{~u[7]}}, ~u[7], u[6:0]};
		sv = {{6{~v[7]}}, ~v[7], v[6:0]};
		r = $signed({6'h00, yy}) + sv + ((14'sd3 * sv) >>> 3);
		b = $signed({6'h00, yy}) + su + ((14'sd47 * su) >>> 6);
		r = r < 0 ? 14'sd0 : (r > 255 ? 14'sd255 : r);
		b = b < 0 ? 14'sd0 : (b > 255 ? 14'sd255 : b);
		wr(isc_pkg::REG_CTRL, {30'h0, sd, 1'b0});
		ycc_valid <= 1'b1;
		ycc_comp <= isc_pkg::COMP_Y;
		ycc_data <= yy;
		@(posedge clk);
		ycc_comp <= isc_pkg::COMP_U;
		ycc_data <= u;
		@(posedge clk);
		ycc_comp <= isc_pkg::COMP_V;
		ycc_data <= v;
		@(posedge clk);
		ycc_valid <= 1'b0;
		@(negedge clk);
		chk({pci_valid, sdram_valid}, {~sd, sd});
		chk(rgb, {r[7:0], yy, b[7:0]});
		@(negedge clk);
		chk({pci_valid, sdram_valid}, 2'b00);
		@(posedge clk);
	endtask

	// ********************************
	// Sequence
	// ********************************
	initial begin
		logic [31:0] d;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd(isc_pkg::REG_X_INC, d);
		chk(d, 32'h0001_0000);
		rd(isc_pkg::REG_X_START, d);
		chk(d, 32'h0000_0000);
		rd(8'hFC, d);
		chk(d, 32'h0000_0000);
		wr(isc_pkg::REG_Y_INC, 32'h0002_8001);
		rd(isc_pkg::REG_Y_INC, d);
		chk(d, 32'h0002_8001);
		$display("Register test done at %0t", $time);
		// Vertical x2 upscale from -1/4 line
		y_inc = 32'h0000_8000;
		y = 32'hFFFF_C000 + 32'h0000_8000;
		wr(isc_pkg::REG_Y_START, 32'hFFFF_C000);
		wr(isc_pkg::REG_Y_INC, y_inc);
		wr(isc_pkg::REG_CTRL, 32'h0000_0008);
		@(negedge clk);
		@(negedge clk);
		chk(vpos, {y[31:16], ~y[15], y[14:11]});
		chk(v_advance, 16'h0000);
		@(posedge clk);
		run_line(32'hFFFF_C000, 32'h0001_0000, 4, 20, 1'b0, 1'b0);
		rd(isc_pkg::REG_X_POS, d);
		chk(d, 32'h0003_4000);
		rd(isc_pkg::REG_STATUS, d);
		chk(d, 32'h0006_0000);
		rd(isc_pkg::REG_Y_POS, d);
		chk(d, 32'h0000_C000);
		run_line(32'hFFFF_C000, 32'h0000_8000, 6, 20, 1'b0, 1'b1);
		run_line(32'h0000_1234, 32'h0001_0999, 5, 30, 1'b0, 1'b0);
		run_line(32'h0000_0000, 32'h0003_0000, 3, 40, 1'b1, 1'b1);
		run_line(32'h0000_0000, 32'h0001_8000, 8, 6, 1'b0, 1'b0);
		yuv(8'h80, 8'h80, 8'h80, 1'b0);
		yuv(8'h40, 8'hF0, 8'h10, 1'b0);
		yuv(8'hF0, 8'h20, 8'hE0, 1'b1);
		// Lone V must not convert
		ycc_valid <= 1'b1;
		ycc_comp <= isc_pkg::COMP_V;
		@(posedge clk);
		ycc_valid <= 1'b0;
		@(negedge clk);
		chk({pci_valid, sdram_valid}, 2'b00);
		$display("Colour test done at %0t", $time);
		close_out();
	end
endmodule
